// ### sda_defs.svh
// constants for the servo drive alarm manager: register map, field
// positions, the fixed cause table and timing counts.
// assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
//
// Functional notes
// [RULE1] show active alarm or warning code
// [RULE2] malfunction output drops on any alarm
// [RULE3] decel stop: forced decel, then brake
// [RULE4] brake-only stop: brake at once
// [RULE5] warnings clear alone once cause gone
// [RULE6] alarm latched until cause gone, allowed reset
// [RULE7] discrete: pin, panel SET, software reset
// [RULE8] networked: command, software; controller reset counts
// [RULE9] code outputs only on discrete variant
// [RULE10] code outputs need parameter lowest digit 1
// [RULE11] code is three bits, bit 0 to 2
// [RULE12] warnings never produce a code pattern
// [RULE13] no alarm means no code asserted
// [RULE14] history skips parameter error and warnings, not resilience
// [RULE15] controller should drop servo-on, cut power
// [RULE16] undervoltage: control brake-only, main decel
// [RULE17] code holds until alarm clears, then off
`ifndef SDA_DEFS_SVH
`define SDA_DEFS_SVH

// ============================================================
// register byte offsets
`define SDA_A_CTRL      8'h00
`define SDA_A_PARAM     8'h04
`define SDA_A_STATUS    8'h08
`define SDA_A_HSEL      8'h0C
`define SDA_A_HDATA     8'h10

// ============================================================
// field positions and reset values
`define SDA_CTRL_SWRST  0
`define SDA_PARAM_RST   32'h0000_0000
`define SDA_DIGIT_ON    4'h1

// ============================================================
// cause table word: {code[15:8], warn[7], stop[6:5], rok[4],
// cok[3], acd[2:0]}; stop 01 decel-then-brake, 10 brake only
`define SDA_NCAUSE      8
`define SDA_F_WARN      7
`define SDA_F_ROK       4
`define SDA_F_COK       3
`define SDA_CAUSE0      16'h105A   // [RULE16] control supply: brake only
`define SDA_CAUSE1      16'h103A   // [RULE16] main supply: decel first
`define SDA_CAUSE2      16'h1240
`define SDA_CAUSE3      16'h1340
`define SDA_CAUSE4      16'h1440
`define SDA_CAUSE5      16'h3741
`define SDA_CAUSE6      16'hE180
`define SDA_CAUSE7      16'hF080
`define SDA_CODE_PERR   8'h37
`define SDA_IDX_RESIL   7

// ============================================================
// timing
`define SDA_CLK_MHZ     100
`define SDA_DECEL_US    10000
`define SDA_DECEL_CYC   (`SDA_DECEL_US * `SDA_CLK_MHZ)

`endif

// ### sda_pkg.sv
// types shared by the alarm manager modules.
// assumes nothing of its surroundings.
package sda_pkg;

  // stop sequencer states
  typedef enum logic [2:0] {
    SDA_RUN   = 3'b001,
    SDA_DECEL = 3'b010,
    SDA_BRAKE = 3'b100
  } sda_stop_st_t;

  // stop method field of a cause word
  typedef enum logic [1:0] {
    SDA_SM_NONE  = 2'b00,
    SDA_SM_DECEL = 2'b01,
    SDA_SM_BRAKE = 2'b10,
    SDA_SM_RSV   = 2'b11
  } sda_stop_m_t;

endpackage

// ### sda_hist.sv
// alarm history log: eight entries, newest first on readout.
// assumes one write strobe per cycle from the alarm manager.
`timescale 1ns/1ns
`default_nettype none
module sda_hist
  import sda_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_code,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_code,
  output logic      [3:0] count
);

  logic [7:0] mem [8];
  logic [2:0] wp_ff;
  logic [3:0] cnt_ff;
  logic [2:0] rd_ptr;

  // ==========================================================
  // write side: circular store, count saturates at eight
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff  <= 3'h0;
      cnt_ff <= 4'h0;
    end else if (ce && wr_en) begin
      wp_ff  <= wp_ff + 3'h1;
      cnt_ff <= (cnt_ff == 4'h8) ? cnt_ff : cnt_ff + 4'h1;
    end
  end

  // entry data needs no reset, the count guards the readout
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wp_ff] <= wr_code;
    end
  end

  // ==========================================================
  // read side: index 0 is the newest entry, empty slots read 0
  assign rd_ptr  = wp_ff - 3'h1 - rd_idx;
  assign rd_code = ({1'b0, rd_idx} < cnt_ff) ? mem[rd_ptr] : 8'h00;
  assign count   = cnt_ff;

endmodule // sda_hist
`default_nettype wire

// ### sda_alarm_mgr.sv
// servo drive alarm manager: latches alarms, shows codes, runs the
// stop sequence, drives malfunction and alarm code outputs.
// assumes inputs synchronous to clk, AHB-Lite slave with one master.
//
// Chosen here: the AHB-Lite register port and the address map.
`include "sda_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sda_alarm_mgr
  import sda_pkg::*;
#(
  parameter int DECEL_CYC = `SDA_DECEL_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [7:0]  fault_cause,
  input  wire logic        networked_strap,
  input  wire logic        alarm_reset_input,
  input  wire logic        panel_set_button,
  input  wire logic        panel_alarm_screen,
  input  wire logic        error_reset_cmd,
  input  wire logic        controller_reset,
  output logic             malfunction_output,
  output logic             decel_then_brake_stop,
  output logic             brake_only_stop,
  output logic      [7:0]  disp_code,
  output logic             disp_on,
  output logic             disp_warn,
  output logic      [2:0]  alarm_code
);

  localparam int NC = `SDA_NCAUSE;
  localparam logic [15:0] CTBL [NC] = '{
    `SDA_CAUSE0, `SDA_CAUSE1, `SDA_CAUSE2, `SDA_CAUSE3,
    `SDA_CAUSE4, `SDA_CAUSE5, `SDA_CAUSE6, `SDA_CAUSE7
  };

  // lowest set index wins; used for alarms and warnings alike
  function automatic logic [2:0] first_set(input logic [NC-1:0] v);
    first_set = 3'h0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  // ==========================================================
  // state
  logic         alarm_lat_ff, nxt_alarm_lat;
  logic [2:0]   alarm_idx_ff, nxt_alarm_idx;
  logic         net_ff, strap_done_ff;
  logic         rin_q_ff, set_q_ff, err_q_ff, cpu_q_ff, f0_q_ff;
  logic [31:0]  param_ff;
  logic [2:0]   hist_sel_ff;
  logic         sw_rst_ff;
  sda_stop_st_t st_ff, nxt_st;
  logic [23:0]  dcnt_ff;
  logic         malf_ff, dtb_ff, bro_ff;
  logic [7:0]   disp_code_ff, nxt_disp_code;
  logic         disp_on_ff, disp_warn_ff;
  logic [2:0]   acd_ff, nxt_acd;
  logic [31:0]  hrdata_ff, rd_mux;
  logic         hready_ff, hresp_ff, wr_pend_ff;
  logic [7:0]   wr_addr_ff;

  // ==========================================================
  // cause classification
  logic [NC-1:0] alm_pres, wrn_pres;
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cls
      assign alm_pres[g] = fault_cause[g] & ~CTBL[g][`SDA_F_WARN];
      assign wrn_pres[g] = fault_cause[g] & CTBL[g][`SDA_F_WARN];
    end
  endgenerate

  wire [2:0]  new_idx  = first_set(alm_pres);
  wire [15:0] new_w    = CTBL[new_idx];
  wire [2:0]  wrn_idx  = first_set(wrn_pres);
  wire        wrn_any  = |wrn_pres;
  wire [15:0] lat_w    = CTBL[alarm_idx_ff];
  wire        new_alm  = ~alarm_lat_ff & (|alm_pres);
  wire        gone     = ~fault_cause[alarm_idx_ff];
  wire sda_stop_m_t new_sm = sda_stop_m_t'(new_w[6:5]);

  // ==========================================================
  // reset sources, each taken on its rising edge
  wire rin_rise = alarm_reset_input & ~rin_q_ff;
  wire set_rise = panel_set_button & ~set_q_ff & panel_alarm_screen
                  & alarm_lat_ff;
  wire err_rise = error_reset_cmd & ~err_q_ff;
  wire cpu_rise = controller_reset & ~cpu_q_ff;
  // discrete variant: pin, panel SET, software
  wire rst_disc = rin_rise | set_rise | sw_rst_ff;          // [RULE7]
  // networked variant: controller command, software
  wire rst_net  = err_rise | sw_rst_ff;                     // [RULE8]
  wire alm_rst  = net_ff ? rst_net : rst_disc;
  // a controller reset acts as the CPU reset method
  wire cpu_rst  = net_ff & cpu_rise;                        // [RULE8]
  // only the methods permitted for the latched alarm clear it
  wire clr_ok   = alarm_lat_ff & gone &
                  ((alm_rst & lat_w[`SDA_F_ROK]) |
                   (cpu_rst & lat_w[`SDA_F_COK]));          // [RULE6]

  // ==========================================================
  // alarm latch: holds across cause removal until a reset method
  assign nxt_alarm_lat = new_alm | (alarm_lat_ff & ~clr_ok); // [RULE6]
  assign nxt_alarm_idx = new_alm ? new_idx : alarm_idx_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_lat_ff <= 1'b0;
      alarm_idx_ff <= 3'h0;
    end else if (ce) begin
      alarm_lat_ff <= nxt_alarm_lat;
      alarm_idx_ff <= nxt_alarm_idx;
    end
  end

  // edge history of reset inputs and the resilience warning
  always_ff @(posedge clk) begin
    if (rst) begin
      rin_q_ff <= 1'b0;
      set_q_ff <= 1'b0;
      err_q_ff <= 1'b0;
      cpu_q_ff <= 1'b0;
      f0_q_ff  <= 1'b0;
    end else if (ce) begin
      rin_q_ff <= alarm_reset_input;
      set_q_ff <= panel_set_button;
      err_q_ff <= error_reset_cmd;
      cpu_q_ff <= controller_reset;
      f0_q_ff  <= fault_cause[`SDA_IDX_RESIL];
    end
  end

  // variant strap caught once, on the first enabled edge after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      net_ff        <= 1'b0;
      strap_done_ff <= 1'b0;
    end else if (ce && !strap_done_ff) begin
      net_ff        <= networked_strap;
      strap_done_ff <= 1'b1;
    end
  end

  // ==========================================================
  // stop sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      SDA_RUN: begin
        if (new_alm && new_sm == SDA_SM_DECEL) begin
          nxt_st = SDA_DECEL;                               // [RULE3]
        end else if (new_alm && new_sm == SDA_SM_BRAKE) begin
          nxt_st = SDA_BRAKE;                               // [RULE4]
        end
      end
      SDA_DECEL: begin
        if (!nxt_alarm_lat) begin
          nxt_st = SDA_RUN;
        end else if (dcnt_ff == 24'(DECEL_CYC - 1)) begin
          nxt_st = SDA_BRAKE;                               // [RULE3]
        end
      end
      SDA_BRAKE: begin
        if (!nxt_alarm_lat) begin
          nxt_st = SDA_RUN;
        end
      end
      default: nxt_st = SDA_RUN;
    endcase
  end

  // state, decel timer and stop outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff   <= SDA_RUN;
      dcnt_ff <= 24'h00_0000;
      dtb_ff  <= 1'b0;
      bro_ff  <= 1'b0;
    end else if (ce) begin
      st_ff   <= nxt_st;
      dcnt_ff <= (st_ff == SDA_DECEL) ? dcnt_ff + 24'h00_0001
                                      : 24'h00_0000;
      dtb_ff  <= (nxt_st == SDA_DECEL);
      bro_ff  <= (nxt_st == SDA_BRAKE);
    end
  end

  // ==========================================================
  // display: alarm first, else warning, else blank
  assign nxt_disp_code = nxt_alarm_lat ? CTBL[nxt_alarm_idx][15:8] :
                         wrn_any       ? CTBL[wrn_idx][15:8]       :
                                         8'h00;              // [RULE1]

  // alarm code: discrete variant, parameter digit set, alarm held
  wire acd_ok = ~net_ff & (param_ff[3:0] == `SDA_DIGIT_ON); // [RULE9] [RULE10]
  // warnings never enter the latch, so give no pattern
  assign nxt_acd = (nxt_alarm_lat && acd_ok)                 // [RULE13]
                 ? CTBL[nxt_alarm_idx][2:0] : 3'h0; // [RULE11] [RULE12]

  always_ff @(posedge clk) begin
    if (rst) begin
      malf_ff      <= 1'b1;
      disp_code_ff <= 8'h00;
      disp_on_ff   <= 1'b0;
      disp_warn_ff <= 1'b0;
      acd_ff       <= 3'h0;
    end else if (ce) begin
      malf_ff      <= ~nxt_alarm_lat;                        // [RULE2]
      disp_code_ff <= nxt_disp_code;                         // [RULE1]
      disp_on_ff   <= nxt_alarm_lat | wrn_any;               // [RULE5]
      disp_warn_ff <= ~nxt_alarm_lat & wrn_any;
      acd_ff       <= nxt_acd;                               // [RULE17]
    end
  end

  // ==========================================================
  // history: new alarms except parameter error, resilience rises
  wire f0_rise = fault_cause[`SDA_IDX_RESIL] & ~f0_q_ff;
  wire h_alm   = new_alm & (new_w[15:8] != `SDA_CODE_PERR);
  wire hist_wr = h_alm | f0_rise;                            // [RULE14]
  wire [7:0] hist_code = h_alm ? new_w[15:8]
                               : CTBL[`SDA_IDX_RESIL][15:8];
  logic [7:0] hist_rd;
  logic [3:0] hist_cnt;

  sda_hist u_hist (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (hist_wr),
    .wr_code (hist_code),
    .rd_idx  (hist_sel_ff),
    .rd_code (hist_rd),
    .count   (hist_cnt)
  );

  // ==========================================================
  // AHB-Lite slave: zero wait, read data registered at address
  wire acc = hsel & hready & htrans[1];

  always_comb begin
    case (haddr[7:0])
      `SDA_A_PARAM:  rd_mux = param_ff;
      `SDA_A_STATUS: rd_mux = {13'h0000, net_ff, malf_ff, acd_ff,
                               st_ff, alarm_lat_ff, disp_warn_ff,
                               disp_on_ff, disp_code_ff};
      `SDA_A_HSEL:   rd_mux = {29'h0000_0000, hist_sel_ff};
      `SDA_A_HDATA:  rd_mux = {20'h0_0000, hist_cnt, hist_rd};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  wire mapped = (haddr[31:8] == 24'h00_0000);
  wire wr_now = wr_pend_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      hready_ff  <= 1'b1;
      hresp_ff   <= 1'b0;
      hrdata_ff  <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (ce) begin
      hrdata_ff  <= (acc && !hwrite && mapped) ? rd_mux : 32'h0000_0000;
      wr_pend_ff <= acc & hwrite & mapped;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // data-phase writes; control bit is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      param_ff    <= `SDA_PARAM_RST;
      hist_sel_ff <= 3'h0;
      sw_rst_ff   <= 1'b0;
    end else if (ce) begin
      sw_rst_ff <= wr_now && wr_addr_ff == `SDA_A_CTRL &&
                   hwdata[`SDA_CTRL_SWRST];                  // [RULE7]
      if (wr_now && wr_addr_ff == `SDA_A_PARAM) begin
        param_ff <= hwdata;                                  // [RULE10]
      end
      if (wr_now && wr_addr_ff == `SDA_A_HSEL) begin
        hist_sel_ff <= hwdata[2:0];
      end
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout             = hready_ff;
  assign hresp                 = hresp_ff;
  assign hrdata                = hrdata_ff;
  assign malfunction_output    = malf_ff;
  assign decel_then_brake_stop = dtb_ff;
  assign brake_only_stop       = bro_ff;
  assign disp_code             = disp_code_ff;
  assign disp_on               = disp_on_ff;
  assign disp_warn             = disp_warn_ff;
  assign alarm_code            = acd_ff;

  // ==========================================================
  // checks
  AST_MALF_DROP: assert property (@(posedge clk) disable iff (rst)
    ce && new_alm |=> !malfunction_output && alarm_lat_ff) // [RULE2]
    else $error("malfunction output not dropped on alarm");

  AST_DECEL_FIRST: assert property (@(posedge clk) disable iff (rst)
    ce && st_ff == SDA_RUN && new_alm && new_sm == SDA_SM_DECEL
    |=> decel_then_brake_stop && !brake_only_stop) // [RULE3]
    else $error("decel stop skipped deceleration");

  AST_BRAKE_NOW: assert property (@(posedge clk) disable iff (rst)
    ce && st_ff == SDA_RUN && new_alm && new_sm == SDA_SM_BRAKE
    |=> brake_only_stop && !decel_then_brake_stop) // [RULE4]
    else $error("brake-only stop not immediate");

  AST_WARN_AUTO: assert property (@(posedge clk) disable iff (rst)
    ce && disp_warn_ff && !wrn_any && !alarm_lat_ff && !(|alm_pres)
    |=> !disp_on && disp_code == 8'h00) // [RULE5]
    else $error("warning did not clear with its cause");

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && alarm_lat_ff && !clr_ok
    |=> alarm_lat_ff && $stable(alarm_idx_ff)) // [RULE6]
    else $error("alarm cleared without a permitted reset");

  AST_NET_NOCODE: assert property (@(posedge clk) disable iff (rst)
    ce && net_ff |=> alarm_code == 3'h0) // [RULE9]
    else $error("networked variant drove an alarm code");

  AST_PARAM_GATE: assert property (@(posedge clk) disable iff (rst)
    ce && param_ff[3:0] != `SDA_DIGIT_ON |=> alarm_code == 3'h0) // [RULE10]
    else $error("alarm code without parameter enable");

  AST_IDLE_CODE: assert property (@(posedge clk) disable iff (rst)
    ce && !alarm_lat_ff && !(|alm_pres) |=> alarm_code == 3'h0) // [RULE13]
    else $error("alarm code asserted with no alarm");

  AST_UV_CTRL: assert property (@(posedge clk) disable iff (rst)
    ce && st_ff == SDA_RUN && !alarm_lat_ff && fault_cause[0]
    |=> brake_only_stop) // [RULE16]
    else $error("control undervoltage did not brake at once");

  AST_NO_PERR_LOG: assert property (@(posedge clk) disable iff (rst)
    hist_wr |-> hist_code != `SDA_CODE_PERR) // [RULE14]
    else $error("parameter error written to history");

endmodule // sda_alarm_mgr
`default_nettype wire

// ### sda_ctl_model.sv
// far-side model: controller or discrete input device that pulses one
// reset source on request and drops servo-on once an alarm is seen.
// assumes the bench raises kick for one cycle per request.
`timescale 1ns/1ns
`default_nettype none
module sda_ctl_model (
  input  wire logic       clk,
  input  wire logic       kick,
  input  wire logic [1:0] src,
  input  wire logic       malfunction_output,
  output logic            alarm_reset_input,
  output logic            panel_set_button,
  output logic            error_reset_cmd,
  output logic            controller_reset,
  output logic            servo_on
);
  // ============================================================
  // reset sources
  initial begin
    alarm_reset_input = 1'h0;
    panel_set_button  = 1'h0;
    error_reset_cmd   = 1'h0;
    controller_reset  = 1'h0;
    servo_on          = 1'h0;
  end
  // one-cycle pulse on the chosen source, low between requests
  always @(posedge clk) begin
    alarm_reset_input <= kick && src == 2'h0;
    panel_set_button  <= kick && src == 2'h1;
    error_reset_cmd   <= kick && src == 2'h2;
    controller_reset  <= kick && src == 2'h3;
  end
  // servo-on follows the malfunction output, off while alarmed
  always @(posedge clk) begin
    servo_on <= malfunction_output === 1'h1;
  end
endmodule // sda_ctl_model
`default_nettype wire

// ### servo_drive_alarm_manager_bench.sv
// testbench for the alarm manager: cause table rows, then reset
// sources, history, networked variant and the register bus.
// assumes the design and the controller model in the same folder.
`timescale 1ns/1ns
`default_nettype none
module servo_drive_alarm_manager_bench;
  import sda_pkg::*;
  localparam int DCY = 8;
  typedef struct {
    logic [7:0] msk; logic [7:0] code; logic [2:0] acd;
    logic sd; logic db; logic w;
  } sda_row_t;
  logic        clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        strap = 1'h0, scr = 1'h0, kick = 1'h0, ce = 1'h1;
  logic [1:0]  htrans = 2'h0, src = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [7:0]  cause = 8'h00;
  logic        hreadyout, hresp, mal, sd, db, on, warn;
  logic        ari, psb, erc, crs, servo_on_input;
  logic [31:0] hrdata, obs, ex;
  logic [7:0]  code;
  logic [2:0]  acd;
  int          fails = 0, num_checks = 0, cycles = 0;
  sda_row_t    rows[8] = '{
    '{8'h01, 8'h10, 3'h2, 1'h0, 1'h1, 1'h0},
    '{8'h02, 8'h10, 3'h2, 1'h1, 1'h0, 1'h0},
    '{8'h04, 8'h12, 3'h0, 1'h0, 1'h1, 1'h0},
    '{8'h08, 8'h13, 3'h0, 1'h0, 1'h1, 1'h0},
    '{8'h10, 8'h14, 3'h0, 1'h0, 1'h1, 1'h0},
    '{8'h20, 8'h37, 3'h1, 1'h0, 1'h1, 1'h0},
    '{8'h40, 8'hE1, 3'h0, 1'h0, 1'h0, 1'h1},
    '{8'h80, 8'hF0, 3'h0, 1'h0, 1'h0, 1'h1}};
  // ============================================================
  // clock, instances, observed outputs
  always #5 clk = ~clk;
  assign obs = {16'h0, on, warn, code, mal, sd, db, acd};
  sda_alarm_mgr #(.DECEL_CYC(DCY)) i_sda_alarm_mgr (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fault_cause(cause), .networked_strap(strap),
    .alarm_reset_input(ari), .panel_set_button(psb),
    .panel_alarm_screen(scr), .error_reset_cmd(erc),
    .controller_reset(crs), .malfunction_output(mal),
    .decel_then_brake_stop(sd), .brake_only_stop(db), .disp_code(code),
    .disp_on(on), .disp_warn(warn), .alarm_code(acd));
  sda_ctl_model i_sda_ctl_model (
    .clk(clk), .kick(kick), .src(src), .malfunction_output(mal),
    .alarm_reset_input(ari), .panel_set_button(psb),
    .error_reset_cmd(erc), .controller_reset(crs), .servo_on(servo_on_input));
  // ============================================================
  // tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // single word transfer; waits for hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    cyc(3);
  endtask
  task automatic fc(input logic [7:0] v);
    @(posedge clk);
    cause <= v;
    cyc(3);
  endtask
  task automatic kk(input logic [1:0] s);
    @(posedge clk);
    src <= s;
    kick <= 1'h1;
    @(posedge clk);
    kick <= 1'h0;
    cyc(4);
  endtask
  // power cycle, choosing the variant strap
  task automatic pwr(input logic s);
    @(posedge clk);
    rst <= 1'h1;
    strap <= s;
    cause <= 8'h00;
    cyc(2);
    rst <= 1'h0;
    cyc(3);
  endtask
  // ============================================================
  // timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
  // ============================================================
  // main sequence
  initial begin
    cyc(20);
    rst <= 1'h0;
    cyc(3);
    chk(obs, 32'h20);
    $display("reset test done");
    foreach (rows[i]) begin
      pwr(1'h0);
      bus(1'h1, 32'h04, 32'h1);
      fc(rows[i].msk);
      ex = {16'h0, 1'h1, rows[i].w, rows[i].code, rows[i].w,
        rows[i].sd, rows[i].db, rows[i].acd};
      chk(obs & 32'hFFE7, ex & 32'hFFE7);
      chk(obs & 32'h18, ex & 32'h18);
      fc(8'h00);
      ex = rows[i].w ? 32'h20 : {16'h0, 2'h2, rows[i].code, 3'h0, rows[i].acd};
      chk(obs & 32'hFFE7, ex);
    end
    $display("cause table test done");
    pwr(1'h0);
    bus(1'h1, 32'h04, 32'h10);
    fc(8'h02);
    cyc(DCY);
    chk(obs & 32'h1F, 32'h08);
    $display("decel and code select test done");
    // clock enable low freezes the latch, release lets it act
    pwr(1'h0);
    ce <= 1'h0;
    fc(8'h01);
    chk(obs, 32'h20);
    ce <= 1'h1;
    cyc(2);
    chk(obs & 32'h20, 32'h0);
    $display("clock enable test done");
    pwr(1'h0);
    fc(8'h01);
    kk(2'h0);
    chk(obs & 32'h20, 32'h0);
    fc(8'h00);
    kk(2'h0);
    chk(obs, 32'h20);
    fc(8'h01);
    fc(8'h00);
    kk(2'h1);
    kk(2'h2);
    chk(obs & 32'h20, 32'h0);
    scr <= 1'h1;
    kk(2'h1);
    chk(obs & 32'h20, 32'h20);
    fc(8'h01);
    fc(8'h00);
    bus(1'h1, 32'h00, 32'h1);
    chk(obs & 32'h20, 32'h20);
    fc(8'h40);
    fc(8'h80);
    fc(8'h20);
    fc(8'h00);
    kk(2'h0);
    bus(1'h1, 32'h00, 32'h1);
    chk(obs & 32'h3FE0, 32'h0DC0);
    bus(1'h1, 32'h0C, 32'h0);
    bus(1'h0, 32'h10, 32'h0);
    chk(rd & 32'hFFF, 32'h4F0);
    bus(1'h1, 32'h0C, 32'h1);
    bus(1'h0, 32'h10, 32'h0);
    chk(rd & 32'hFF, 32'h10);
    $display("reset source and history test done");
    pwr(1'h1);
    bus(1'h1, 32'h04, 32'h1);
    fc(8'h01);
    chk(obs & 32'h27, 32'h0);
    chk({31'h0, servo_on_input}, 32'h0);
    fc(8'h00);
    kk(2'h0);
    chk(obs & 32'h20, 32'h0);
    kk(2'h3);
    chk(obs, 32'h20);
    fc(8'h01);
    fc(8'h00);
    kk(2'h2);
    chk(obs, 32'h20);
    bus(1'h0, 32'h04, 32'h0);
    chk(rd, 32'h1);
    bus(1'h0, 32'h40, 32'h0);
    chk({rd[31:1], hresp}, 32'h0);
    $display("networked and bus test done");
    print_verdict();
  end
endmodule // servo_drive_alarm_manager_bench
`default_nettype wire
